// *** rtl/plc_pkg.sv ***
// Contract
// - four-input lookup table realises any function
// - addnsub selects one-bit add or subtract
// - one register and carry-select chain per cell
// - carry chain continues into adjacent cluster
// - register has cluster-driven clear and preset
// - preset loads logic one at the next sys_clk edge
// - clear wins over simultaneous preset
// - two clears and one preset per cluster
// - enabled device-wide clear overrides everything
// - controls derived from six row clocks, local
// - combinational output drives next cell's fast input
// - register output feeds next register input
`default_nettype none
package plc_pkg;

	localparam int CELL_COUNT  = 10;
	localparam int LUT_INPUTS  = 4;
	localparam int LUT_SIZE    = 16;
	localparam int ROW_CLOCKS  = 6;
	localparam int LOCAL_CTRLS = 2;
	localparam int CTRL_SEL_W  = 3;

	localparam logic REG_RESET_VALUE = 1'h0;
	localparam logic CLEAR_VALUE     = 1'h0;
	localparam logic PRESET_VALUE    = 1'h1;
	localparam logic PIN_N_IDLE      = 1'h1;

	typedef enum logic [1:0] {
		PLC_DSEL_LUT    = 2'h0,
		PLC_DSEL_CHAIN  = 2'h1,
		PLC_DSEL_DIRECT = 2'h2
	} plc_dsel_t;

	typedef enum logic [1:0] {
		PLC_CLR_NONE = 2'h0,
		PLC_CLR_0    = 2'h1,
		PLC_CLR_1    = 2'h2
	} plc_clr_sel_t;

	typedef struct packed {
		logic [LUT_SIZE-1:0] lut_mask;
		logic                arith;
		logic                lut_chain;
		plc_dsel_t           dsel;
		plc_clr_sel_t        clr_sel;
		logic                preset_en;
	} plc_cell_cfg_t;

	typedef struct packed {
		logic [CTRL_SEL_W-1:0] clk_sel;
		logic [CTRL_SEL_W-1:0] clr0_sel;
		logic [CTRL_SEL_W-1:0] clr1_sel;
		logic [CTRL_SEL_W-1:0] preset_sel;
		logic [CTRL_SEL_W-1:0] addnsub_sel;
		logic                  dev_clear_en;
		logic                  carry_cascade;
	} plc_cluster_cfg_t;

	typedef struct packed {
		logic d;
		logic c;
		logic b;
		logic a;
	} plc_cell_in_t;

	// picks one of the six row clocks or two local control lines
	function automatic logic plc_ctrl_pick(
		input logic [ROW_CLOCKS-1:0]  row,
		input logic [LOCAL_CTRLS-1:0] loc,
		input logic [CTRL_SEL_W-1:0]  sel
	);
		logic [ROW_CLOCKS+LOCAL_CTRLS-1:0] src;
		src = {loc, row};
		return src[sel];
	endfunction

endpackage
`default_nettype wire

// *** rtl/plc_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_cell (
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire plc_pkg::plc_cell_cfg_t cfg,
	input  wire plc_pkg::plc_cell_in_t  data,
	input  wire logic                   chain_in,
	input  wire logic                   reg_chain_in,
	input  wire logic                   carry_in,
	input  wire logic                   addnsub,
	input  wire logic                   clk_en,
	input  wire logic                   clear,
	input  wire logic                   preset,
	input  wire logic                   dev_clear,
	output logic                        lut_out,
	output logic                        carry_out,
	output logic                        reg_q
);
	import plc_pkg::*;

	logic                  d_eff;
	logic                  b_eff;
	logic [LUT_INPUTS-1:0] lut_idx;
	logic                  sum;
	logic                  carry0;
	logic                  carry1;
	logic                  reg_d;
	logic                  next_reg_q;

	always_comb begin
		d_eff     = cfg.lut_chain ? chain_in : data.d;
		lut_idx   = {d_eff, data.c, data.b, data.a};
		b_eff     = data.b ^ ~addnsub;
		sum       = data.a ^ b_eff ^ carry_in;
		carry0    = data.a & b_eff;
		carry1    = data.a | b_eff;
		carry_out = cfg.arith ? (carry_in ? carry1 : carry0) : carry_in;
		lut_out   = cfg.arith ? sum : cfg.lut_mask[lut_idx];
	end

	always_comb begin
		unique case (cfg.dsel)
			PLC_DSEL_LUT:    reg_d = lut_out;
			PLC_DSEL_CHAIN:  reg_d = reg_chain_in;
			PLC_DSEL_DIRECT: reg_d = data.c;
			default:         reg_d = lut_out;
		endcase
		next_reg_q = reg_q;
		if (dev_clear) begin
			next_reg_q = CLEAR_VALUE;
		end else if (clear) begin
			next_reg_q = CLEAR_VALUE;
		end else if (preset) begin
			next_reg_q = PRESET_VALUE;
		end else if (clk_en) begin
			next_reg_q = reg_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			reg_q <= REG_RESET_VALUE;
		end else begin
			reg_q <= next_reg_q;
		end
	end

endmodule // plc_cell
`default_nettype wire

// *** rtl/plc_cluster.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_cluster (
	input  wire logic                                       sys_clk,
	input  wire logic                                       rstn,
	input  wire plc_pkg::plc_cluster_cfg_t                  cluster_cfg,
	input  wire plc_pkg::plc_cell_cfg_t [plc_pkg::CELL_COUNT-1:0] cell_cfg,
	input  wire plc_pkg::plc_cell_in_t  [plc_pkg::CELL_COUNT-1:0] cell_in,
	input  wire logic [plc_pkg::ROW_CLOCKS-1:0]             row_clock,
	input  wire logic [plc_pkg::LOCAL_CTRLS-1:0]            local_ctrl,
	input  wire logic                                       device_wide_clear_n,
	input  wire logic                                       carry_chain_in,
	input  wire logic                                       reg_chain_in,
	output logic [plc_pkg::CELL_COUNT-1:0]                  comb_q,
	output logic [plc_pkg::CELL_COUNT-1:0]                  reg_q,
	output logic                                            carry_chain_out,
	output logic                                            reg_chain_out
);
	import plc_pkg::*;

	logic [ROW_CLOCKS-1:0] row_meta;
	logic [ROW_CLOCKS-1:0] row_sync;
	logic [ROW_CLOCKS-1:0] next_row_meta;
	logic [ROW_CLOCKS-1:0] next_row_sync;
	logic                  dclr_meta_n;
	logic                  dclr_sync_n;
	logic                  next_dclr_meta_n;
	logic                  next_dclr_sync_n;
	logic                  clk_prev;
	logic                  next_clk_prev;
	logic [CELL_COUNT-1:0] next_comb_q;

	logic                  clk_level;
	logic                  clk_en;
	logic                  clr0;
	logic                  clr1;
	logic                  preset;
	logic                  addnsub;
	logic                  dev_clear;
	logic                  carry_seed;
	logic [CELL_COUNT-1:0] carry_to;
	logic [CELL_COUNT-1:0] carry_from;
	logic [CELL_COUNT-1:0] lut_out;
	logic [CELL_COUNT-1:0] cell_clear;
	logic [CELL_COUNT-1:0] cell_preset;
	logic [CELL_COUNT-1:0] lut_chain_src;
	logic [CELL_COUNT-1:0] reg_chain_src;

	// pin synchronisers and clock edge memory
	always_comb begin
		next_row_meta    = row_clock;
		next_row_sync    = row_meta;
		next_dclr_meta_n = device_wide_clear_n;
		next_dclr_sync_n = dclr_meta_n;
		next_clk_prev    = clk_level;
		next_comb_q      = lut_out;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			row_meta    <= '0;
			row_sync    <= '0;
			dclr_meta_n <= PIN_N_IDLE;
			dclr_sync_n <= PIN_N_IDLE;
			clk_prev    <= '0;
			comb_q      <= '0;
		end else begin
			row_meta    <= next_row_meta;
			row_sync    <= next_row_sync;
			dclr_meta_n <= next_dclr_meta_n;
			dclr_sync_n <= next_dclr_sync_n;
			clk_prev    <= next_clk_prev;
			comb_q      <= next_comb_q;
		end
	end

	// cluster-wide controls
	always_comb begin
		clk_level = plc_ctrl_pick(row_sync, local_ctrl, cluster_cfg.clk_sel);
		clk_en    = clk_level & ~clk_prev;
		clr0      = plc_ctrl_pick(row_sync, local_ctrl, cluster_cfg.clr0_sel);
		clr1      = plc_ctrl_pick(row_sync, local_ctrl, cluster_cfg.clr1_sel);
		preset    = plc_ctrl_pick(row_sync, local_ctrl, cluster_cfg.preset_sel);
		addnsub   = plc_ctrl_pick(row_sync, local_ctrl, cluster_cfg.addnsub_sel);
		dev_clear = cluster_cfg.dev_clear_en & ~dclr_sync_n;
		carry_seed = cluster_cfg.carry_cascade ? carry_chain_in : ~addnsub;
		carry_to   = {carry_from[CELL_COUNT-2:0], carry_seed};
	end

	// per-cell control and chain routing
	always_comb begin
		for (int i = 0; i < CELL_COUNT; i++) begin
			unique case (cell_cfg[i].clr_sel)
				PLC_CLR_NONE: cell_clear[i] = 1'h0;
				PLC_CLR_0:    cell_clear[i] = clr0;
				PLC_CLR_1:    cell_clear[i] = clr1;
				default:      cell_clear[i] = 1'h0;
			endcase
			cell_preset[i] = cell_cfg[i].preset_en & preset;
			if (i == 0) begin
				lut_chain_src[i] = cell_in[i].d;
				reg_chain_src[i] = reg_chain_in;
			end else begin
				lut_chain_src[i] = lut_out[i-1];
				reg_chain_src[i] = reg_q[i-1];
			end
		end
	end

	for (genvar g = 0; g < CELL_COUNT; g++) begin : g_cell
		plc_cell u_cell (
			.sys_clk      (sys_clk),
			.rstn         (rstn),
			.cfg          (cell_cfg[g]),
			.data         (cell_in[g]),
			.chain_in     (lut_chain_src[g]),
			.reg_chain_in (reg_chain_src[g]),
			.carry_in     (carry_to[g]),
			.addnsub      (addnsub),
			.clk_en       (clk_en),
			.clear        (cell_clear[g]),
			.preset       (cell_preset[g]),
			.dev_clear    (dev_clear),
			.lut_out      (lut_out[g]),
			.carry_out    (carry_from[g]),
			.reg_q        (reg_q[g])
		);
	end

	always_comb begin
		carry_chain_out = carry_from[CELL_COUNT-1];
		reg_chain_out   = reg_q[CELL_COUNT-1];
	end

endmodule // plc_cluster
`default_nettype wire

// *** dv/plc_cluster_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_cluster_sva (
	input wire logic                                          sys_clk,
	input wire logic                                          rstn,
	input wire plc_pkg::plc_cluster_cfg_t                     cluster_cfg,
	input wire plc_pkg::plc_cell_cfg_t [plc_pkg::CELL_COUNT-1:0] cell_cfg,
	input wire plc_pkg::plc_cell_in_t  [plc_pkg::CELL_COUNT-1:0] cell_in,
	input wire logic [plc_pkg::LOCAL_CTRLS-1:0]               local_ctrl,
	input wire logic                                          device_wide_clear_n,
	input wire logic [plc_pkg::CELL_COUNT-1:0]                comb_q,
	input wire logic [plc_pkg::CELL_COUNT-1:0]                reg_q
);
	import plc_pkg::*;
	logic p1, p2, lp, ok, edg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// device clear pin as the cluster sees it
	always_ff @(posedge sys_clk) begin
		p1 <= rstn ? device_wide_clear_n : 1'h1;
		p2 <= rstn ? p1 : 1'h1;
		lp <= rstn & local_ctrl[0];
	end
	assign ok  = !cluster_cfg.dev_clear_en || p2;
	assign edg = ok && cluster_cfg.clk_sel == 3'h6 && local_ctrl[0] && !lp;
	function automatic logic free(input plc_cell_cfg_t c);
		return c.clr_sel == PLC_CLR_NONE && !c.preset_en;
	endfunction
	property p_dclr;
		cluster_cfg.dev_clear_en && !p2 |=> reg_q == '0;
	endproperty
	a_dclr: assert property (p_dclr) else $error("device clear missed");
	property p_clr;
		cluster_cfg.clr0_sel == 3'h7 && local_ctrl[1] && cell_cfg[3].clr_sel == PLC_CLR_0
			|=> !reg_q[3];
	endproperty
	a_clr: assert property (p_clr) else $error("clear lost");
	property p_pre;
		ok && cluster_cfg.preset_sel == 3'h7 && local_ctrl[1] && cell_cfg[6].preset_en
			&& cell_cfg[6].clr_sel == PLC_CLR_NONE |=> reg_q[6];
	endproperty
	a_pre: assert property (p_pre) else $error("preset lost");
	property p_cap;
		edg && cell_cfg[0].dsel == PLC_DSEL_DIRECT && free(cell_cfg[0])
			|=> reg_q[0] == $past(cell_in[0].c);
	endproperty
	a_cap: assert property (p_cap) else $error("capture wrong");
	property p_hold;
		ok && cluster_cfg.clk_sel == 3'h6 && !edg && free(cell_cfg[0]) |=> $stable(reg_q[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved");
	property p_shift;
		edg && cell_cfg[5].dsel == PLC_DSEL_CHAIN && free(cell_cfg[5])
			|=> reg_q[5] == $past(reg_q[4]);
	endproperty
	a_shift: assert property (p_shift) else $error("shift wrong");
	property p_lut;
		!cell_cfg[1].arith && !cell_cfg[1].lut_chain
			|=> comb_q[1] == $past(cell_cfg[1].lut_mask[cell_in[1]]);
	endproperty
	a_lut: assert property (p_lut) else $error("lookup wrong");
	property p_chain;
		cell_cfg[4].lut_chain && !cell_cfg[4].arith |=> comb_q[4] == cell_cfg[4].lut_mask[
			{comb_q[3], $past(cell_in[4].c), $past(cell_in[4].b), $past(cell_in[4].a)}];
	endproperty
	a_chain: assert property (p_chain) else $error("lookup chain wrong");
endmodule // plc_cluster_sva
bind plc_cluster plc_cluster_sva u_sva (.sys_clk, .rstn, .cluster_cfg, .cell_cfg, .cell_in,
	.local_ctrl, .device_wide_clear_n, .comb_q, .reg_q);
`default_nettype wire

// *** dv/plc_cluster_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_cluster_tb;
	import plc_pkg::*;
	logic                           sys_clk = 1'h0;
	logic                           rstn = 1'h0;
	plc_cluster_cfg_t               ccfg;
	plc_cell_cfg_t [CELL_COUNT-1:0] cfg;
	plc_cell_in_t  [CELL_COUNT-1:0] din;
	logic [ROW_CLOCKS-1:0]          row = '0;
	logic [LOCAL_CTRLS-1:0]         loc = '0;
	logic                           dclr_n = 1'h1;
	logic                           cin = 1'h0;
	logic [CELL_COUNT-1:0]          comb_q, reg_q;
	logic                           cout, rout;
	int                             err_total = 0, total_checks = 0;
	// {a, b, add, cascade, carry in, carry out, sum}
	localparam logic [6:0] ROWS [9] = '{7'h10, 7'h31, 7'h72, 7'h02, 7'h21, 7'h62, 7'h5e,
		7'h28, 7'h4a};
	always #25 sys_clk = ~sys_clk;
	plc_cluster u_dut (.sys_clk(sys_clk), .rstn(rstn), .cluster_cfg(ccfg), .cell_cfg(cfg),
		.cell_in(din), .row_clock(row), .local_ctrl(loc), .device_wide_clear_n(dclr_n),
		.carry_chain_in(cin), .reg_chain_in(1'h0), .comb_q(comb_q), .reg_q(reg_q),
		.carry_chain_out(cout), .reg_chain_out(rout));
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'h1) begin
			err_total++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (400) @(posedge sys_clk);
		err_total++;
		wrap_up();
	end
	initial begin
		ccfg = '{clk_sel: 3'h6, clr0_sel: 3'h7, clr1_sel: 3'h0, preset_sel: 3'h7,
			addnsub_sel: 3'h7, dev_clear_en: 1'h1, carry_cascade: 1'h0};
		for (int i = 0; i < CELL_COUNT; i++)
			cfg[i] = '{lut_mask: 16'h6996, arith: 1'h0, lut_chain: 1'h0, dsel: PLC_DSEL_LUT,
				clr_sel: PLC_CLR_NONE, preset_en: 1'h0};
		cfg[0].arith = 1'h1;
		cfg[0].dsel = PLC_DSEL_DIRECT;
		cfg[1].lut_mask = 16'h8e71;
		cfg[3].clr_sel = PLC_CLR_0;
		cfg[3].preset_en = 1'h1;
		cfg[4].lut_chain = 1'h1;
		cfg[5].dsel = PLC_DSEL_CHAIN;
		cfg[6].preset_en = 1'h1;
		din = '0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'h1;
		#1 chk(reg_q === '0 && comb_q === '0, "reset");
		// arithmetic rows, cells 1, 3 and 4 fed a moving pattern
		foreach (ROWS[i]) begin
			@(posedge sys_clk);
			{din[0].a, din[0].b, loc[1], ccfg.carry_cascade, cin} <= ROWS[i][6:2];
			{din[4], din[3], din[1]} <= {3{4'(i)}} ^ 12'h5a3;
			@(posedge sys_clk);
			#1 chk(cout === ROWS[i][1] && comb_q[0] === ROWS[i][0], "arith");
		end
		@(posedge sys_clk);
		loc <= 2'h0;
		din[0].c <= 1'h1;
		@(posedge sys_clk);
		loc[0] <= 1'h1;
		@(posedge sys_clk);
		#1 chk(reg_q[0] === 1'h1, "capture");
		@(posedge sys_clk);
		din[0].c <= 1'h0;
		repeat (2) @(posedge sys_clk);
		#1 chk(reg_q[0] === 1'h1, "hold");
		@(posedge sys_clk);
		loc[1] <= 1'h1;
		@(posedge sys_clk);
		#1 chk(reg_q[3] === 1'h0 && reg_q[6] === 1'h1, "clear preset");
		@(posedge sys_clk);
		dclr_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		#1 chk(reg_q[6] === 1'h1, "device clear early");
		@(posedge sys_clk);
		#1 chk(reg_q === '0, "device clear");
		@(posedge sys_clk);
		{dclr_n, loc} <= 3'h4;
		ccfg.clk_sel <= 3'h0;
		din[0].c <= 1'h1;
		din[9] <= 4'h1;
		repeat (4) @(posedge sys_clk);
		row[0] <= 1'h1;
		@(posedge sys_clk);
		#1 chk(reg_q[0] === 1'h0 && rout === 1'h0, "row clock early");
		repeat (3) @(posedge sys_clk);
		#1 chk(reg_q[0] === 1'h1 && rout === 1'h1, "row clock");
		wrap_up();
	end
endmodule // plc_cluster_tb
`default_nettype wire
